// *** src/node_config_memory_map_regs.sv ***
// Node configuration register and eight memory map entries on a plain
// strobe bus, with node reset sequencing and memory address decode.
// Assumes one core clock, sync active-low reset, 32-bit writes only.
`timescale 1ns/1ps
module node_config_memory_map_regs
    import cfgmap_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [DATA_W-1:0] REG_RDATA_OUT,
    input wire logic BUS_RESET_IN,
    input wire logic [MEM_ADDR_W-1:0] MATCH_ADDR_IN,
    output logic MATCH_HIT_OUT,
    output logic [NODE_ID_W-1:0] MATCH_NODE_OUT,
    output logic CONSOLE_MODE_OUT,
    output logic NODE_RESET_OUT,
    output logic CORRECTABLE_CHECK_ENABLE_OUT
);
    // Offset is a map entry slot
    function automatic logic is_map(input logic [ADDR_W-1:0] a);
        return (a >= MAP_FIRST_OFS) && (a <= MAP_LAST_OFS)
            && ((a & MAP_STEP_MASK) == '0);
    endfunction

    // Node ID of a map entry slot, the low bits of its index
    function automatic logic [NODE_ID_W-1:0] map_idx(input logic [ADDR_W-1:0] a);
        return a[MAP_STEP_LOG2 +: NODE_ID_W];
    endfunction

    node_link_if link ();

    logic stp_reg; // Self-test pending
    logic stp_next;
    logic halt_reg; // Node halt request
    logic halt_next;
    logic join_reg; // Join running system flag
    logic join_next;
    logic cce_reg; // Correctable check enable
    logic cce_next;
    logic console_reg; // Console mode out
    logic console_next;
    logic start_reg; // Reset sequence launch pulse
    logic start_next;
    logic [DATA_W-1:0] map_reg [MAP_COUNT]; // Map entries
    logic [DATA_W-1:0] map_next [MAP_COUNT];
    logic [DATA_W-1:0] rdata_reg; // Read data, one cycle only
    logic [DATA_W-1:0] rdata_next;
    logic bus_rst_meta_reg; // Bus reset synchroniser stage one
    logic bus_rst_sync_reg; // Bus reset synchroniser stage two
    logic hit_reg; // Registered decode hit
    logic hit_next;
    logic [NODE_ID_W-1:0] node_reg; // Registered decode node
    logic [NODE_ID_W-1:0] node_next;
    logic [MAP_COUNT-1:0] hits; // Per-entry comparator results
    logic wr_cfg; // Write strobe to configuration
    logic rd_cfg; // Read strobe to configuration
    logic reset_req_wr; // Node reset written as one

    assign wr_cfg = REG_WR_IN && (REG_ADDR_IN == CFG_OFS);
    assign rd_cfg = REG_RD_IN && (REG_ADDR_IN == CFG_OFS);
    assign reset_req_wr = wr_cfg && REG_WDATA_IN[NODE_RESET_BIT];
    assign link.start = start_reg;

    // Sequencer runs the node reset after a launch
    node_reset_seq u_seq (
        .clk_in (CORE_CLK_IN),
        .rst_b_in (RST_B_IN),
        .link (link.seq)
    );

    // One comparator per mapping entry
    genvar g;
    generate
        for (g = 0; g < MAP_COUNT; g++)
        begin : g_match
            map_entry_match u_match (
                .entry_in (map_reg[g]),
                .addr_in (MATCH_ADDR_IN),
                .hit_out (hits[g])
            );
        end
    endgenerate

    // Bus reset arrives from outside the clock domain
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            bus_rst_meta_reg <= 1'b0;
            bus_rst_sync_reg <= 1'b0;
        end
        else
        begin
            bus_rst_meta_reg <= BUS_RESET_IN;
            bus_rst_sync_reg <= bus_rst_meta_reg;
        end
    end

    // Configuration register next values
    always_comb
    begin
        stp_next = stp_reg;
        halt_next = halt_reg;
        cce_next = cce_reg;
        join_next = join_reg;
        // Clears first so a same-cycle set wins
        if (wr_cfg && REG_WDATA_IN[STP_BIT])
            stp_next = 1'b0;
        if (wr_cfg && REG_WDATA_IN[JOIN_BIT])
            join_next = 1'b0;
        if (bus_rst_sync_reg)
            join_next = 1'b0;
        if (reset_req_wr)
            join_next = 1'b1;
        // The sequence itself never touches the join flag
        if (wr_cfg)
        begin
            halt_next = REG_WDATA_IN[HALT_BIT];
            cce_next = REG_WDATA_IN[CCE_BIT];
        end
        // Node reset is write-only: it launches and is not stored
        start_next = reset_req_wr && !link.busy;
        // The launch pulse keeps console up in the cycle before busy rises
        console_next = halt_next || start_next || start_reg || link.busy;
    end

    // Map entry next values; reserved bits are never stored
    always_comb
    begin
        for (int i = 0; i < MAP_COUNT; i++)
            map_next[i] = map_reg[i];
        // Unaligned offsets fail is_map, so a stray write cannot alias an entry
        if (REG_WR_IN && is_map(REG_ADDR_IN))
            map_next[map_idx(REG_ADDR_IN)] = REG_WDATA_IN & MAP_RW_MASK;
    end

    // Read data mux; unmapped offsets answer zero
    always_comb
    begin
        rdata_next = '0;
        if (rd_cfg)
        begin
            rdata_next[STP_BIT] = stp_reg;
            rdata_next[HALT_BIT] = halt_reg;
            rdata_next[JOIN_BIT] = join_reg;
            rdata_next[CCE_BIT] = cce_reg;
        end
        else if (REG_RD_IN && is_map(REG_ADDR_IN))
            rdata_next = map_reg[map_idx(REG_ADDR_IN)] & MAP_RW_MASK;
    end

    // Address decode; lowest node wins if software overlaps entries
    always_comb
    begin
        hit_next = 1'b0;
        node_next = '0;
        for (int i = MAP_COUNT - 1; i >= 0; i--)
        begin
            if (hits[i])
            begin
                hit_next = 1'b1;
                node_next = NODE_ID_W'(i);
            end
        end
    end

    // Register all state except the bus reset synchroniser
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            stp_reg <= STP_RESET;
            halt_reg <= 1'b0;
            join_reg <= 1'b0;
            cce_reg <= 1'b0;
            console_reg <= 1'b0;
            start_reg <= 1'b0;
            rdata_reg <= '0;
            hit_reg <= 1'b0;
            node_reg <= '0;
            for (int i = 0; i < MAP_COUNT; i++)
                map_reg[i] <= '0;
        end
        else
        begin
            stp_reg <= stp_next;
            halt_reg <= halt_next;
            join_reg <= join_next;
            cce_reg <= cce_next;
            console_reg <= console_next;
            start_reg <= start_next;
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
            node_reg <= node_next;
            for (int i = 0; i < MAP_COUNT; i++)
                map_reg[i] <= map_next[i];
        end
    end

    assign REG_RDATA_OUT = rdata_reg;
    assign MATCH_HIT_OUT = hit_reg;
    assign MATCH_NODE_OUT = node_reg;
    assign CONSOLE_MODE_OUT = console_reg;
    assign NODE_RESET_OUT = link.busy;
    assign CORRECTABLE_CHECK_ENABLE_OUT = cce_reg;

    // Checks on the bank's own behaviour
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    property p_stp_clear;
        wr_cfg && REG_WDATA_IN[STP_BIT] |=> !stp_reg;
    endproperty
    a_stp_clear: assert property (p_stp_clear)
        else $error("self-test pending not cleared by write-one");

    property p_stp_hold;
        stp_reg && !(wr_cfg && REG_WDATA_IN[STP_BIT]) |=> stp_reg;
    endproperty
    a_stp_hold: assert property (p_stp_hold)
        else $error("self-test pending dropped without write-one");

    property p_reset_seq;
        reset_req_wr && !link.busy && !start_reg |=> CONSOLE_MODE_OUT ##1 NODE_RESET_OUT [*8];
    endproperty
    a_reset_seq: assert property (p_reset_seq)
        else $error("node reset did not run its sequence");

    property p_halt_console;
        halt_reg |-> CONSOLE_MODE_OUT;
    endproperty
    a_halt_console: assert property (p_halt_console)
        else $error("halt set but node not in console mode");

    property p_join_set;
        reset_req_wr |=> join_reg;
    endproperty
    a_join_set: assert property (p_join_set)
        else $error("join flag not set by node reset");

    property p_join_bus_clear;
        bus_rst_sync_reg && !reset_req_wr |=> !join_reg;
    endproperty
    a_join_bus_clear: assert property (p_join_bus_clear)
        else $error("join flag survived bus reset");

    property p_join_keep;
        NODE_RESET_OUT && !wr_cfg && !bus_rst_sync_reg |=> $stable(join_reg);
    endproperty
    a_join_keep: assert property (p_join_keep)
        else $error("join flag changed during node reset sequence");

    property p_cfg_reserved;
        rd_cfg |=> REG_RDATA_OUT[JOIN_BIT-1:CCE_BIT+1] == '0;
    endproperty
    a_cfg_reserved: assert property (p_cfg_reserved)
        else $error("configuration reserved bits read non-zero");

    property p_cce_follow;
        wr_cfg |=> CORRECTABLE_CHECK_ENABLE_OUT == $past(REG_WDATA_IN[CCE_BIT]);
    endproperty
    a_cce_follow: assert property (p_cce_follow)
        else $error("check enable does not follow written bit");

    property p_map_readback;
        REG_WR_IN && is_map(REG_ADDR_IN) ##1 REG_RD_IN && $stable(REG_ADDR_IN)
            |=> REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & MAP_RW_MASK);
    endproperty
    a_map_readback: assert property (p_map_readback)
        else $error("map entry did not read back its write");

    // Busy always sits inside console mode
    property p_console_seq;
        NODE_RESET_OUT |-> CONSOLE_MODE_OUT;
    endproperty
    a_console_seq: assert property (p_console_seq)
        else $error("node reset running outside console mode");

    // Node reset is write-only and reads back as zero
    property p_reset_read_zero;
        rd_cfg |=> !REG_RDATA_OUT[NODE_RESET_BIT];
    endproperty
    a_reset_read_zero: assert property (p_reset_read_zero)
        else $error("node reset bit read back as one");

    // Halt takes the written bit
    property p_halt_follow;
        wr_cfg |=> halt_reg == $past(REG_WDATA_IN[HALT_BIT]);
    endproperty
    a_halt_follow: assert property (p_halt_follow)
        else $error("halt does not follow written bit");

    // Write-one clears the join flag unless a node reset sets it
    property p_join_w1c;
        wr_cfg && REG_WDATA_IN[JOIN_BIT] && !reset_req_wr |=> !join_reg;
    endproperty
    a_join_w1c: assert property (p_join_w1c)
        else $error("join flag not cleared by write-one");

    // Reserved map field never reads back
    property p_map_reserved;
        REG_RD_IN && is_map(REG_ADDR_IN) |=> (REG_RDATA_OUT & ~MAP_RW_MASK) == '0;
    endproperty
    a_map_reserved: assert property (p_map_reserved)
        else $error("map entry reserved bits read non-zero");

    // Read data is zero unless a mapped read came just before
    property p_rdata_zero;
        !(rd_cfg || (REG_RD_IN && is_map(REG_ADDR_IN))) |=> REG_RDATA_OUT == '0;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("read data non-zero without a mapped read");

    // Decode hit is the registered OR of the comparators
    property p_hit_follow;
        1'b1 |=> MATCH_HIT_OUT == ($past(hits) != '0);
    endproperty
    a_hit_follow: assert property (p_hit_follow)
        else $error("decode hit disagrees with comparators");

    // No hit reports node zero
    property p_node_zero;
        !MATCH_HIT_OUT |-> MATCH_NODE_OUT == '0;
    endproperty
    a_node_zero: assert property (p_node_zero)
        else $error("decode node non-zero without a hit");

    // Once cleared, pending stays clear until reset; writing one never sets it
    property p_stp_no_set;
        !stp_reg |=> !stp_reg;
    endproperty
    a_stp_no_set: assert property (p_stp_no_set)
        else $error("self-test pending set again by a write");

    // Scenarios worth seeing in coverage
    c_reset_seq: cover property (reset_req_wr ##[1:20] !NODE_RESET_OUT);
    c_halt: cover property (halt_reg ##1 !halt_reg);
    c_join_bus: cover property (join_reg ##1 bus_rst_sync_reg ##1 !join_reg);
    c_hit: cover property (MATCH_HIT_OUT && MATCH_NODE_OUT != '0);
    c_map_rd: cover property (REG_RD_IN && is_map(REG_ADDR_IN));
endmodule // node_config_memory_map_regs

// *** src/cfgmap_pkg.sv ***
// Constants, field layouts and types shared by the node configuration
// and memory map register bank. Assumes a 12-bit byte offset bus.
package cfgmap_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int MAP_COUNT = 8;
    localparam int NODE_ID_W = 3;
    localparam logic [11:0] CFG_OFS = 12'h080;
    localparam logic [11:0] MAP_FIRST_OFS = 12'h200;
    localparam logic [11:0] MAP_LAST_OFS = 12'h3C0;
    localparam logic [11:0] MAP_STEP_MASK = 12'h03F;
    localparam int MAP_STEP_LOG2 = 6;
    // Configuration register bit positions
    localparam int STP_BIT = 31;
    localparam int NODE_RESET_BIT = 30;
    localparam int HALT_BIT = 29;
    localparam int JOIN_BIT = 28;
    localparam int CCE_BIT = 0;
    localparam logic STP_RESET = 1'b1;
    // Map entry fields
    localparam logic [31:0] MAP_RW_MASK = 32'hFFFE07FF;
    localparam int BASE_HI = 31;
    localparam int BASE_LO = 17;
    localparam int BASE_W = 15;
    localparam int BWID_HI = 8;
    localparam int BWID_LO = 5;
    localparam int IPOS_HI = 4;
    localparam int IPOS_LO = 3;
    localparam int INTC_HI = 2;
    localparam int INTC_LO = 1;
    localparam int EN_BIT = 0;
    localparam logic [1:0] INTC_ONE = 2'h0;
    localparam logic [1:0] INTC_TWO = 2'h1;
    localparam logic [1:0] INTC_FOUR = 2'h2;
    // Memory address layout
    localparam int MEM_ADDR_W = 40;
    localparam int MEM_BASE_LO = 25;
    localparam int INTLV_LO = 6;
    // Node reset sequence length
    localparam int CLK_PERIOD_NS = 100;
    localparam int NODE_RESET_NS = 1000;
    localparam int NODE_RESET_CYCLES = (NODE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_CNT_W = 4;
    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_e;
endpackage

// *** src/node_link_if.sv ***
// Handshake between the register bank and the node reset sequencer.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface node_link_if;
    logic start; // One-cycle launch of a reset sequence
    logic busy; // High while the sequence runs
    modport ctl (output start, input busy);
    modport seq (input start, output busy);
endinterface

// *** src/node_reset_seq.sv ***
// Node reset sequencer: holds busy for a fixed number of cycles.
// Assumes a synchronous active-low reset on the core clock.
`timescale 1ns/1ps
module node_reset_seq
    import cfgmap_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    node_link_if.seq link
);
    seq_state_e state_reg; // Sequencer state
    seq_state_e state_next;
    logic [SEQ_CNT_W-1:0] cnt_reg; // Cycles left in the sequence
    logic [SEQ_CNT_W-1:0] cnt_next;
    logic busy_reg; // Registered busy to the bank
    logic busy_next;

    // Next state; a start while running is ignored, not restarted
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            SEQ_IDLE:
            begin
                if (link.start)
                begin
                    state_next = SEQ_RUN;
                    cnt_next = SEQ_CNT_W'(NODE_RESET_CYCLES - 1);
                end
            end
            SEQ_RUN:
            begin
                if (cnt_reg == '0)
                    state_next = SEQ_IDLE;
                else
                    cnt_next = cnt_reg - 1'b1;
            end
            default: state_next = SEQ_IDLE;
        endcase
        busy_next = (state_next == SEQ_RUN);
    end

    // State registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            state_reg <= SEQ_IDLE;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
        end
    end

    assign link.busy = busy_reg;
endmodule // node_reset_seq

// *** src/map_entry_match.sv ***
// One memory map comparator: tests a memory address against an entry.
// Assumes the entry word and address are stable on the core clock.
`timescale 1ns/1ps
module map_entry_match
    import cfgmap_pkg::*;
(
    input wire logic [DATA_W-1:0] entry_in,
    input wire logic [MEM_ADDR_W-1:0] addr_in,
    output logic hit_out
);
    logic [BASE_W-1:0] base; // Stored base bits
    logic [3:0] bwid; // Count of valid upper base bits
    logic [1:0] ipos; // Interleave position
    logic [1:0] intc; // Interleave count code
    logic base_ok;
    logic intl_ok;

    // Base and interleave comparison
    always_comb
    begin
        base = entry_in[BASE_HI:BASE_LO];
        bwid = entry_in[BWID_HI:BWID_LO];
        ipos = entry_in[IPOS_HI:IPOS_LO];
        intc = entry_in[INTC_HI:INTC_LO];
        base_ok = 1'b1;
        // Only the top bwid base bits take part
        for (int j = 0; j < BASE_W; j++)
        begin
            if (j >= BASE_W - int'(bwid))
                base_ok = base_ok & (base[j] == addr_in[MEM_BASE_LO + j]);
        end
        case (intc)
            INTC_ONE: intl_ok = 1'b1;
            INTC_TWO: intl_ok = (ipos[0] == addr_in[INTLV_LO]);
            INTC_FOUR: intl_ok = (ipos == addr_in[INTLV_LO+1:INTLV_LO]);
            default: intl_ok = 1'b0; // Reserved code never matches
        endcase
        hit_out = entry_in[EN_BIT] & base_ok & intl_ok;
    end
endmodule // map_entry_match

// *** tb/node_config_memory_map_regs_bench.sv ***
// Self-checking bench for the node configuration and memory map bank.
// Assumes the plain strobe register bus and a 10 MHz core clock.
`timescale 1ns/1ps
module node_config_memory_map_regs_bench
    import cfgmap_pkg::*;
;
    logic core_clk = 1'b0; // Core clock, 100 ns period
    logic rst_b; // Synchronous reset, active low
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic bus_reset;
    logic [MEM_ADDR_W-1:0] match_addr;
    logic match_hit;
    logic [NODE_ID_W-1:0] match_node;
    logic console_mode;
    logic node_reset;
    logic check_en;
    int err_count; // Mismatches seen
    int n_tests; // Comparisons made
    logic [31:0] map_m [MAP_COUNT]; // Reference copy of the map entries
    logic m_stp; // Reference configuration fields
    logic m_halt;
    logic m_join;
    logic m_cce;

    node_config_memory_map_regs dut_u (
        .CORE_CLK_IN(core_clk),
        .RST_B_IN(rst_b),
        .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata),
        .REG_WR_IN(reg_wr),
        .REG_RD_IN(reg_rd),
        .REG_RDATA_OUT(reg_rdata),
        .BUS_RESET_IN(bus_reset),
        .MATCH_ADDR_IN(match_addr),
        .MATCH_HIT_OUT(match_hit),
        .MATCH_NODE_OUT(match_node),
        .CONSOLE_MODE_OUT(console_mode),
        .NODE_RESET_OUT(node_reset),
        .CORRECTABLE_CHECK_ENABLE_OUT(check_en)
    );

    // Free-running core clock
    always #50 core_clk = ~core_clk;

    // Compare and count; four-state equality so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Single exit point of the run
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One-cycle write strobe, always a full 32-bit word
    task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe; data is only valid in the following cycle
    task automatic read_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Expected configuration word from the reference fields
    function automatic logic [31:0] cfg_exp();
        return {m_stp, 1'b0, m_halt, m_join, 27'h0000000, m_cce};
    endfunction

    task automatic check_cfg(input string what);
        logic [31:0] d;
        read_reg(CFG_OFS, d);
        check(d, cfg_exp(), what);
    endtask

    // Config write plus reference update; set wins over clear for the join flag
    task automatic cfg_write(input logic [31:0] d);
        write_reg(CFG_OFS, d);
        if (d[31])
            m_stp = 1'b0;
        if (d[28])
            m_join = 1'b0;
        if (d[30])
            m_join = 1'b1;
        m_halt = d[29];
        m_cce = d[0];
    endtask

    // Reference decode: lowest enabled entry whose base and interleave agree
    function automatic int exp_node(input logic [MEM_ADDR_W-1:0] a);
        logic [31:0] e;
        int bw;
        bit ok;
        for (int n = 0; n < MAP_COUNT; n++)
        begin
            e = map_m[n];
            bw = int'(e[8:5]);
            ok = e[0];
            for (int j = 0; j < BASE_W; j++)
                if (j >= BASE_W - bw && e[BASE_LO + j] !== a[MEM_BASE_LO + j])
                    ok = 1'b0;
            if (e[2:1] == 2'h1 && e[3] !== a[6])
                ok = 1'b0;
            if (e[2:1] == 2'h2 && e[4:3] !== a[7:6])
                ok = 1'b0;
            if (e[2:1] == 2'h3)
                ok = 1'b0;
            if (ok)
                return n;
        end
        return -1;
    endfunction

    // Reference state after each rst_b reset
    task automatic model_reset();
        m_stp = 1'b1;
        m_halt = 1'b0;
        m_join = 1'b0;
        m_cce = 1'b0;
        for (int n = 0; n < MAP_COUNT; n++)
            map_m[n] = 32'h00000000;
    endtask

    // Cut a hang short; the whole run needs well under 3000 cycles
    initial
    begin
        repeat (6000) @(posedge core_clk);
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done();
    end

    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [MEM_ADDR_W-1:0] a;
        int node;
        int cnt;
        int ccnt;
        int k;
        rst_b = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        bus_reset = 1'b0;
        match_addr = 40'h0000000000;
        err_count = 0;
        n_tests = 0;
        void'($urandom(85153));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        model_reset();
        check_cfg("config after reset");
        // Entries load with every bank and interleave code, random elsewhere
        for (int n = 0; n < MAP_COUNT; n++)
        begin
            d = $urandom;
            d[10:9] = n[1:0];
            d[2:1] = n[1:0];
            write_reg(MAP_FIRST_OFS + 12'(n * 64), d);
            map_m[n] = d & MAP_RW_MASK;
        end
        for (int n = 0; n < MAP_COUNT; n++)
        begin
            read_reg(MAP_FIRST_OFS + 12'(n * 64), d);
            check(d, map_m[n], "map entry");
        end
        // Unaligned and out-of-range offsets hold nothing and disturb nothing
        write_reg(12'h220, 32'hFFFFFFFF);
        read_reg(12'h220, d);
        check(d, 32'h00000000, "unmapped read");
        read_reg(12'h400, d);
        check(d, 32'h00000000, "beyond last entry");
        read_reg(MAP_FIRST_OFS, d);
        check(d, map_m[0], "entry after stray write");
        // Write then read with no gap between the strobes
        d = $urandom;
        map_m[5] = d & MAP_RW_MASK;
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= MAP_FIRST_OFS + 12'(5 * 64);
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, map_m[5], "write then read");
        // Check enable; writing zero to the pending bit must not clear it
        cfg_write(32'h00000001);
        #1;
        check({31'h0, check_en}, 32'h00000001, "check enable on");
        check_cfg("pending still set");
        // Node reset: console at once, then a fixed-length sequence
        cfg_write(32'h40000001);
        #1;
        check({31'h0, console_mode}, 32'h00000001, "console on reset");
        check({31'h0, node_reset}, 32'h00000000, "sequence not yet");
        cnt = 0;
        ccnt = 0;
        repeat (20)
        begin
            @(posedge core_clk);
            #1;
            if (node_reset === 1'b1)
                cnt++;
            if (console_mode === 1'b1)
                ccnt++;
        end
        check(32'(cnt), 32'(NODE_RESET_CYCLES), "sequence length");
        // Console never dips and stays one cycle past the last busy cycle
        check(32'(ccnt), 32'(NODE_RESET_CYCLES + 1), "console span");
        check({31'h0, console_mode}, 32'h00000000, "console released");
        check_cfg("join kept after sequence");
        // Halt holds console mode while set
        cfg_write(32'h20000001);
        #1;
        check({31'h0, console_mode}, 32'h00000001, "halt console");
        check_cfg("halt readback");
        cfg_write(32'h00000000);
        #1;
        check({31'h0, console_mode}, 32'h00000000, "halt cleared");
        check({31'h0, check_en}, 32'h00000000, "check enable off");
        // Write-one clears both sticky flags
        cfg_write(32'h90000000);
        check_cfg("sticky flags cleared");
        // Bus reset command clears the join flag only
        cfg_write(32'h40000000);
        repeat (14) @(posedge core_clk);
        bus_reset <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus_reset <= 1'b0;
        m_join = 1'b0;
        check_cfg("join after bus reset");
        // Address decode against the reference, mostly aimed at an entry
        for (int i = 0; i < 300; i++)
        begin
            k = $urandom_range(7, 0);
            a = MEM_ADDR_W'({$urandom, $urandom});
            if ($urandom_range(3, 0) != 0)
            begin
                a[39:25] = map_m[k][31:17];
                a[7:6] = map_m[k][4:3];
            end
            @(posedge core_clk);
            match_addr <= a;
            @(posedge core_clk);
            #1;
            node = exp_node(a);
            check({31'h0, match_hit}, 32'(node >= 0), "decode hit");
            check({29'h0, match_node}, 32'(node < 0 ? 0 : node), "decode node");
        end
        // Reset in mid-sequence acts as power-up for the join flag
        cfg_write(32'h40000000);
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        model_reset();
        check_cfg("config after second reset");
        check({31'h0, node_reset}, 32'h00000000, "sequence stopped by reset");
        test_done();
    end
endmodule // node_config_memory_map_regs_bench
